//--- event_queue_pkg.sv
// constants shared by the transmit event log / transmit queue control block
package event_queue_pkg;
  // ---------------------------------------------------------------
  // register indices on the register port
  // ---------------------------------------------------------------
  localparam logic [1:0] IDX_EVT_CTRL  = 2'h0;
  localparam logic [1:0] IDX_EVT_STAT  = 2'h1;
  localparam logic [1:0] IDX_EVT_ADDR  = 2'h2;
  localparam logic [1:0] IDX_TXQ_CTRL  = 2'h3;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_PAYLOAD   = 29;
  localparam int POS_DEPTH     = 24;
  localparam int POS_RETRY     = 21;
  localparam int POS_PRIO      = 16;
  localparam int POS_CLEAR     = 10;
  localparam int POS_SEND      = 9;
  localparam int POS_ADVANCE   = 8;
  localparam int POS_QUEUE_TX_ENABLED      = 7;
  localparam int POS_STAMP     = 5;
  localparam int POS_ATT_IE    = 4;
  localparam int POS_QEMPTY_IE = 2;
  localparam int POS_QNFULL_IE = 0;
  localparam int POS_OVF       = 3;
  localparam int POS_FULL      = 2;
  localparam int POS_HALF      = 1;
  localparam int POS_NONEMPTY  = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] RST_DEPTH   = 5'h00;
  localparam logic [2:0] RST_PAYLOAD = 3'h0;
  localparam logic [1:0] RST_RETRY   = 2'h3;
  localparam logic [4:0] RST_PRIO    = 5'h00;
  localparam logic [3:0] RST_IE      = 4'h0;
  localparam logic       RST_CLEAR   = 1'b1;
  // ---------------------------------------------------------------
  // retry field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] RETRY_NONE  = 2'h0;
  localparam logic [1:0] RETRY_THREE = 2'h1;
  localparam logic [1:0] RETRY_UNLIM = 2'h3;
endpackage : event_queue_pkg

//--- event_queue_ctrl.sv
// transmit event log and transmit queue control/status logic with register port
module event_queue_ctrl
  import event_queue_pkg::*;
#(
  parameter logic [31:0] EVT_BASE_ADDR  = 32'h0000_0400,
  parameter int          EVT_OBJ_BYTES  = 12,
  parameter int          EVT_STAMP_BYTES = 4
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        config_mode,
  input  wire logic        retry_limit_global_enable,
  input  wire logic        reg_wr,
  input  wire logic [1:0]  reg_idx,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        evt_push,
  input  wire logic        txq_done,
  input  wire logic        txq_aborted,
  input  wire logic        txq_attempts_exhausted,
  output logic             evt_store_stamp,
  output logic             evt_write_accept,
  output logic [4:0]       evt_head,
  output logic             evt_irq,
  output logic [6:0]       payload_bytes,
  output logic [1:0]       retry_limit_eff,
  output logic [4:0]       queue_priority,
  output logic             send_request,
  output logic             abort_request,
  output logic [4:0]       txq_head,
  output logic [4:0]       txq_tail,
  output logic             txq_empty,
  output logic             txq_notfull,
  output logic             txq_irq
);
  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic wr_evt_ctrl, wr_evt_stat, wr_txq_ctrl;
  assign wr_evt_ctrl = reg_wr && (reg_idx == IDX_EVT_CTRL);
  assign wr_evt_stat = reg_wr && (reg_idx == IDX_EVT_STAT);
  assign wr_txq_ctrl = reg_wr && (reg_idx == IDX_TXQ_CTRL);

  function automatic logic [4:0] wrap_inc(input logic [4:0] p, input logic [4:0] dfield);
    wrap_inc = (p == dfield) ? 5'h00 : 5'(p + 5'h01);
  endfunction : wrap_inc

  // ---------------------------------------------------------------
  // event log configuration
  // ---------------------------------------------------------------
  logic [4:0] evt_depth_ff;
  logic       evt_stamp_ff;
  logic [3:0] evt_ie_ff;
  logic       evt_clear_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      evt_depth_ff <= RST_DEPTH;
      evt_stamp_ff <= 1'b0;
    end else if (wr_evt_ctrl && config_mode) begin
      evt_depth_ff <= reg_wdata[POS_DEPTH +: 5];
      evt_stamp_ff <= reg_wdata[POS_STAMP];
    end
  end
  always_ff @(posedge clk) begin
    if (srst)
      evt_ie_ff <= RST_IE;
    else if (wr_evt_ctrl)
      evt_ie_ff <= reg_wdata[3:0];
  end
  // set for one cycle on a write, held while configuring, then dropped once pointers are cleared
  always_ff @(posedge clk) begin
    if (srst)
      evt_clear_ff <= RST_CLEAR;
    else
      evt_clear_ff <= config_mode || (wr_evt_ctrl && reg_wdata[POS_CLEAR]);
  end

  // ---------------------------------------------------------------
  // event log pointers and level
  // ---------------------------------------------------------------
  logic [4:0] evt_head_ff, evt_tail_ff;
  logic [5:0] evt_cnt_ff;
  logic [5:0] evt_depth_n;
  logic       evt_full, evt_half, evt_nonempty, evt_pop, evt_wr;
  assign evt_depth_n  = 6'({1'b0, evt_depth_ff} + 6'h01);
  assign evt_full     = (evt_cnt_ff == evt_depth_n);
  assign evt_half     = ({evt_cnt_ff, 1'b0} >= {1'b0, evt_depth_n});
  assign evt_nonempty = (evt_cnt_ff != 6'h00);
  // the advance bit is never stored: it acts only in the write cycle
  assign evt_pop      = wr_evt_ctrl && reg_wdata[POS_ADVANCE] && evt_nonempty && !evt_clear_ff;
  assign evt_wr       = evt_push && !evt_full && !evt_clear_ff;
  always_ff @(posedge clk) begin
    if (srst || evt_clear_ff) begin
      evt_head_ff <= 5'h00;
      evt_tail_ff <= 5'h00;
      evt_cnt_ff  <= 6'h00;
    end else begin
      if (evt_wr)
        evt_head_ff <= wrap_inc(evt_head_ff, evt_depth_ff);
      if (evt_pop)
        evt_tail_ff <= wrap_inc(evt_tail_ff, evt_depth_ff);
      if (evt_wr && !evt_pop)
        evt_cnt_ff <= 6'(evt_cnt_ff + 6'h01);
      else if (evt_pop && !evt_wr)
        evt_cnt_ff <= 6'(evt_cnt_ff - 6'h01);
    end
  end

  // overflow: a push into a full log is dropped; the set beats a same-cycle clear
  logic evt_ovf_ff;
  always_ff @(posedge clk) begin
    if (srst)
      evt_ovf_ff <= 1'b0;
    else if (evt_push && evt_full && !evt_clear_ff)
      evt_ovf_ff <= 1'b1;
    else if (wr_evt_stat && !reg_wdata[POS_OVF])
      evt_ovf_ff <= 1'b0;
  end

  logic [3:0] evt_flags;
  assign evt_flags        = {evt_ovf_ff, evt_full, evt_half, evt_nonempty};
  assign evt_irq          = |(evt_flags & evt_ie_ff);
  assign evt_store_stamp  = evt_wr && evt_stamp_ff;
  assign evt_write_accept = evt_wr;
  assign evt_head         = evt_head_ff;

  // tail address; its value is only meaningful outside configuration mode
  logic [31:0] evt_obj_size, evt_addr;
  assign evt_obj_size = evt_stamp_ff ? 32'(EVT_OBJ_BYTES + EVT_STAMP_BYTES) : 32'(EVT_OBJ_BYTES);
  assign evt_addr     = 32'(EVT_BASE_ADDR + 32'(evt_tail_ff) * evt_obj_size);

  // ---------------------------------------------------------------
  // transmit queue configuration
  // ---------------------------------------------------------------
  logic [2:0] txq_payload_ff;
  logic [4:0] txq_depth_ff, txq_prio_ff;
  logic [1:0] txq_retry_ff;
  logic [2:0] txq_ie_ff;
  logic       txq_clear_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      txq_payload_ff <= RST_PAYLOAD;
      txq_depth_ff   <= RST_DEPTH;
    end else if (wr_txq_ctrl && config_mode) begin
      txq_payload_ff <= reg_wdata[POS_PAYLOAD +: 3];
      txq_depth_ff   <= reg_wdata[POS_DEPTH +: 5];
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      txq_retry_ff <= RST_RETRY;
      txq_prio_ff  <= RST_PRIO;
      txq_ie_ff    <= 3'h0;
    end else if (wr_txq_ctrl) begin
      txq_retry_ff <= reg_wdata[POS_RETRY +: 2];
      txq_prio_ff  <= reg_wdata[POS_PRIO +: 5];
      txq_ie_ff    <= {reg_wdata[POS_ATT_IE], reg_wdata[POS_QEMPTY_IE], reg_wdata[POS_QNFULL_IE]};
    end
  end
  always_ff @(posedge clk) begin
    if (srst)
      txq_clear_ff <= RST_CLEAR;
    else
      txq_clear_ff <= config_mode || (wr_txq_ctrl && reg_wdata[POS_CLEAR]);
  end

  // ---------------------------------------------------------------
  // transmit queue pointers and send request
  // ---------------------------------------------------------------
  logic [4:0] txq_head_ff, txq_tail_ff;
  logic [5:0] txq_cnt_ff;
  logic       txq_full, txq_push, txq_pop, sw_send_set, sw_send_clr;
  assign txq_full    = (txq_cnt_ff == 6'({1'b0, txq_depth_ff} + 6'h01));
  assign txq_empty   = (txq_cnt_ff == 6'h00);
  assign txq_notfull = !txq_full;
  assign txq_push    = wr_txq_ctrl && reg_wdata[POS_ADVANCE] && !txq_full && !txq_clear_ff;
  assign txq_pop     = (txq_done || txq_aborted) && !txq_empty && !txq_clear_ff;
  always_ff @(posedge clk) begin
    if (srst || txq_clear_ff) begin
      txq_head_ff <= 5'h00;
      txq_tail_ff <= 5'h00;
      txq_cnt_ff  <= 6'h00;
    end else begin
      if (txq_push)
        txq_head_ff <= wrap_inc(txq_head_ff, txq_depth_ff);
      if (txq_pop)
        txq_tail_ff <= wrap_inc(txq_tail_ff, txq_depth_ff);
      if (txq_push && !txq_pop)
        txq_cnt_ff <= 6'(txq_cnt_ff + 6'h01);
      else if (txq_pop && !txq_push)
        txq_cnt_ff <= 6'(txq_cnt_ff - 6'h01);
    end
  end

  // a software clear only requests the abort; the bit falls when the engine reports it
  logic send_ff;
  assign sw_send_set = wr_txq_ctrl && reg_wdata[POS_SEND];
  assign sw_send_clr = wr_txq_ctrl && !reg_wdata[POS_SEND] && send_ff;
  always_ff @(posedge clk) begin
    if (srst || txq_clear_ff)
      send_ff <= 1'b0;
    else if (sw_send_set)
      send_ff <= 1'b1;
    else if (txq_aborted || (txq_done && txq_cnt_ff == 6'h01))
      send_ff <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (srst)
      abort_request <= 1'b0;
    else
      abort_request <= sw_send_clr && !txq_clear_ff;
  end

  // ---------------------------------------------------------------
  // transmit queue outputs
  // ---------------------------------------------------------------
  always_comb begin
    unique case (txq_payload_ff)
      3'h0: payload_bytes = 7'd8;
      3'h1: payload_bytes = 7'd12;
      3'h2: payload_bytes = 7'd16;
      3'h3: payload_bytes = 7'd20;
      3'h4: payload_bytes = 7'd24;
      3'h5: payload_bytes = 7'd32;
      3'h6: payload_bytes = 7'd48;
      3'h7: payload_bytes = 7'd64;
    endcase
  end
  // without the global limit the field is ignored and retries are unlimited
  assign retry_limit_eff = retry_limit_global_enable ? txq_retry_ff : RETRY_UNLIM;
  assign queue_priority  = txq_prio_ff;
  assign send_request    = send_ff;
  assign txq_head        = txq_head_ff;
  assign txq_tail        = txq_tail_ff;
  assign txq_irq = (txq_ie_ff[2] && txq_attempts_exhausted) || (txq_ie_ff[1] && txq_empty)
                || (txq_ie_ff[0] && txq_notfull);

  // ---------------------------------------------------------------
  // read-back
  // ---------------------------------------------------------------
  always_comb begin
    reg_rdata = 32'h0000_0000;
    unique case (reg_idx)
      IDX_EVT_CTRL: begin
        reg_rdata[POS_DEPTH +: 5] = evt_depth_ff;
        reg_rdata[POS_CLEAR]      = evt_clear_ff;
        reg_rdata[POS_STAMP]      = evt_stamp_ff;
        reg_rdata[3:0]            = evt_ie_ff;
      end
      IDX_EVT_STAT: reg_rdata[3:0] = evt_flags;
      IDX_EVT_ADDR: reg_rdata = evt_addr;
      IDX_TXQ_CTRL: begin
        reg_rdata[POS_PAYLOAD +: 3] = txq_payload_ff;
        reg_rdata[POS_DEPTH +: 5]   = txq_depth_ff;
        reg_rdata[POS_RETRY +: 2]   = txq_retry_ff;
        reg_rdata[POS_PRIO +: 5]    = txq_prio_ff;
        reg_rdata[POS_CLEAR]        = txq_clear_ff;
        reg_rdata[POS_SEND]         = send_ff;
        reg_rdata[POS_QUEUE_TX_ENABLED]         = 1'b1;
        reg_rdata[POS_ATT_IE]       = txq_ie_ff[2];
        reg_rdata[POS_QEMPTY_IE]    = txq_ie_ff[1];
        reg_rdata[POS_QNFULL_IE]    = txq_ie_ff[0];
      end
    endcase
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_depth_cfg_only;
    @(posedge clk) disable iff (srst) (wr_evt_ctrl && !config_mode) |=> $stable(evt_depth_ff) && $stable(evt_stamp_ff);
  endproperty
  a_depth_cfg_only: assert property (p_depth_cfg_only) else $error("depth changed outside config mode");
  property p_clear_self;
    @(posedge clk) disable iff (srst) (evt_clear_ff && !config_mode && !wr_evt_ctrl) |=> !evt_clear_ff && evt_cnt_ff == 6'h00;
  endproperty
  a_clear_self: assert property (p_clear_self) else $error("clear bit did not self-clear");
  property p_clear_cfg;
    @(posedge clk) disable iff (srst) config_mode |=> evt_clear_ff && txq_clear_ff;
  endproperty
  a_clear_cfg: assert property (p_clear_cfg) else $error("clear bit low in config mode");
  property p_pop_one;
    @(posedge clk) disable iff (srst) (evt_pop && !evt_wr) |=> evt_cnt_ff == $past(evt_cnt_ff) - 6'h01;
  endproperty
  a_pop_one: assert property (p_pop_one) else $error("advance did not remove one message");
  property p_ovf_sticky;
    @(posedge clk) disable iff (srst) (evt_ovf_ff && !(wr_evt_stat && !reg_wdata[POS_OVF])) |=> evt_ovf_ff;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");
  property p_full_depth;
    @(posedge clk) disable iff (srst) evt_cnt_ff <= evt_depth_n && (evt_full == (evt_cnt_ff == {1'b0, evt_depth_ff} + 6'h01));
  endproperty
  a_full_depth: assert property (p_full_depth) else $error("occupancy beyond depth");
  property p_irq_gate;
    @(posedge clk) disable iff (srst) (evt_ie_ff == 4'h0) |-> !evt_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("event interrupt without enable");
  property p_send_hold;
    @(posedge clk) disable iff (srst) (send_ff && !txq_done && !txq_aborted && !txq_clear_ff) |=> send_ff;
  endproperty
  a_send_hold: assert property (p_send_hold) else $error("send request dropped without cause");
  property p_abort_req;
    @(posedge clk) disable iff (srst) (sw_send_clr && !txq_clear_ff) |=> abort_request ##1 !abort_request || sw_send_clr;
  endproperty
  a_abort_req: assert property (p_abort_req) else $error("abort request not pulsed");
  property p_stamp;
    @(posedge clk) disable iff (srst) evt_store_stamp |-> evt_stamp_ff && evt_write_accept;
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp stored while disabled");
endmodule : event_queue_ctrl

//--- engine_model.sv
// engine-side model: logs transmissions and reports queue completions
module engine_model (
  input  wire logic clk,
  input  wire logic evt_write_accept,
  input  wire logic evt_store_stamp,
  output logic      evt_push,
  output logic      txq_done,
  output logic      txq_aborted,
  output logic      txq_attempts_exhausted
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    evt_push = 1'b0;
    txq_done = 1'b0;
    txq_aborted = 1'b0;
    txq_attempts_exhausted = 1'b0;
  end
  // ---------------------------------------------------------------
  // one-cycle engine events: 0 push, 1 done, 2 abort
  // ---------------------------------------------------------------
  task automatic pulse(input int which, output logic [1:0] seen);
    @(negedge clk);
    case (which)
      0: evt_push = 1'b1;
      1: txq_done = 1'b1;
      default: txq_aborted = 1'b1;
    endcase
    // accept and stamp answer in the same cycle
    #1 seen = {evt_write_accept, evt_store_stamp};
    @(negedge clk);
    evt_push = 1'b0;
    txq_done = 1'b0;
    txq_aborted = 1'b0;
  endtask : pulse
  task automatic exhaust(input logic v);
    @(negedge clk);
    txq_attempts_exhausted = v;
  endtask : exhaust
endmodule : engine_model

//--- event_queue_ctrl_tb_top.sv
// self-checking bench for the event log and transmit queue control block
module event_queue_ctrl_tb_top
  import event_queue_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // settings and signals
  // ---------------------------------------------------------------
  localparam logic [31:0] BASE = 32'h0000_0400;
  localparam int          OBJ  = 16;
  localparam logic [31:0] EC   = 32'h0300_002f;
  localparam logic [31:0] QC   = 32'h033f_0010;
  logic        clk = 1'b0, srst = 1'b1, config_mode = 1'b1, rl_gen = 1'b0;
  logic        reg_wr, evt_push, txq_done, txq_aborted, txq_attempts_exhausted;
  logic [1:0]  reg_idx, retry_limit_eff;
  logic [31:0] reg_wdata, reg_rdata;
  logic        evt_store_stamp, evt_write_accept, evt_irq, send_request, abort_request;
  logic [4:0]  evt_head, queue_priority, txq_head, txq_tail;
  logic [6:0]  payload_bytes;
  logic        txq_empty, txq_notfull, txq_irq;
  int          n_mismatch = 0, num_checks = 0;
  logic [6:0]  pl [8] = '{7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
  logic [3:0]  st [6] = '{4'h0, 4'h1, 4'h3, 4'h3, 4'h7, 4'hf};

  initial begin
    forever #4 clk = ~clk;
  end

  event_queue_ctrl #(.EVT_BASE_ADDR(BASE), .EVT_OBJ_BYTES(12), .EVT_STAMP_BYTES(4)) i_event_queue_ctrl (
    .clk, .srst, .config_mode, .retry_limit_global_enable(rl_gen), .reg_wr, .reg_idx, .reg_wdata,
    .reg_rdata, .evt_push, .txq_done, .txq_aborted, .txq_attempts_exhausted, .evt_store_stamp,
    .evt_write_accept, .evt_head, .evt_irq, .payload_bytes, .retry_limit_eff, .queue_priority,
    .send_request, .abort_request, .txq_head, .txq_tail, .txq_empty, .txq_notfull, .txq_irq);

  engine_model i_engine_model (.clk, .evt_write_accept, .evt_store_stamp, .evt_push, .txq_done,
    .txq_aborted, .txq_attempts_exhausted);

  // ---------------------------------------------------------------
  // register port tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] idx, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_idx = idx;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rchk(input string what, input logic [1:0] idx, input logic [31:0] exp);
    @(negedge clk);
    reg_idx = idx;
    #1 chk(what, reg_rdata, exp);
  endtask : rchk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [1:0] ac;
    reg_wr = 1'b0;
    reg_idx = 2'h0;
    reg_wdata = 32'h0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    rchk("evt_ctrl", IDX_EVT_CTRL, 32'h0000_0400);
    rchk("evt_stat", IDX_EVT_STAT, 32'h0);
    rchk("txq_ctrl", IDX_TXQ_CTRL, 32'h0060_0480);
    chk("retry_eff", retry_limit_eff, 32'h3);
    for (int i = 0; i < 8; i++) begin
      wr(IDX_TXQ_CTRL, 32'(i) << POS_PAYLOAD);
      chk("payload", payload_bytes, pl[i]);
    end
    wr(IDX_EVT_CTRL, EC);
    wr(IDX_TXQ_CTRL, QC);
    rl_gen = 1'b1;
    #1 chk("retry_eff", retry_limit_eff, 32'h1);
    chk("prio", queue_priority, 32'h1f);
    config_mode = 1'b0;
    // software waits three cycles for the clear bit to fall before anything else
    repeat (3) @(negedge clk);
    rchk("evt_ctrl", IDX_EVT_CTRL, EC);
    rchk("txq_ctrl", IDX_TXQ_CTRL, QC | 32'h80);
    wr(IDX_EVT_CTRL, 32'h0000_000f);
    wr(IDX_TXQ_CTRL, QC | 32'he000_0000);
    rchk("evt_ctrl", IDX_EVT_CTRL, EC);
    rchk("txq_ctrl", IDX_TXQ_CTRL, QC | 32'h80);
    // read address only sampled outside configuration mode
    rchk("evt_addr", IDX_EVT_ADDR, BASE);
    for (int i = 1; i <= 5; i++) begin
      i_engine_model.pulse(0, ac);
      chk("accept", ac, (i < 5) ? 32'h3 : 32'h0);
      rchk("evt_stat", IDX_EVT_STAT, st[i]);
    end
    chk("evt_head", evt_head, 32'h0);
    chk("evt_irq", evt_irq, 32'h1);
    wr(IDX_EVT_STAT, 32'h8);
    rchk("evt_stat", IDX_EVT_STAT, 32'hf);
    wr(IDX_EVT_STAT, 32'h0);
    rchk("evt_stat", IDX_EVT_STAT, 32'h7);
    wr(IDX_EVT_CTRL, 32'h0);
    chk("evt_irq", evt_irq, 32'h0);
    wr(IDX_EVT_CTRL, 32'h4);
    chk("evt_irq", evt_irq, 32'h1);
    for (int j = 1; j <= 5; j++) begin
      wr(IDX_EVT_CTRL, 32'h0000_0104);
      rchk("evt_addr", IDX_EVT_ADDR, BASE + 32'((j % 4) * OBJ) * (j < 5));
      rchk("evt_stat", IDX_EVT_STAT, st[(j < 5) ? 4 - j : 0]);
    end
    rchk("evt_ctrl", IDX_EVT_CTRL, 32'h0300_0024);
    i_engine_model.pulse(0, ac);
    wr(IDX_EVT_CTRL, 32'h0000_0404);
    rchk("evt_stat", IDX_EVT_STAT, 32'h0);
    chk("evt_head", evt_head, 32'h0);
    // transmit queue: one message sent to completion
    wr(IDX_TXQ_CTRL, QC | 32'h100);
    chk("txq_head", txq_head, 32'h1);
    chk("txq_empty", txq_empty, 32'h0);
    wr(IDX_TXQ_CTRL, QC | 32'h200);
    chk("send", send_request, 32'h1);
    i_engine_model.pulse(1, ac);
    chk("send", send_request, 32'h0);
    chk("txq_tail", txq_tail, 32'h1);
    for (int j = 0; j < 5; j++) begin
      wr(IDX_TXQ_CTRL, QC | 32'h100);
    end
    chk("txq_head", txq_head, 32'h1);
    chk("notfull", txq_notfull, 32'h0);
    i_engine_model.exhaust(1'b1);
    #1 chk("txq_irq", txq_irq, 32'h1);
    i_engine_model.exhaust(1'b0);
    #1 chk("txq_irq", txq_irq, 32'h0);
    wr(IDX_TXQ_CTRL, QC | 32'h200);
    wr(IDX_TXQ_CTRL, QC);
    chk("abort", abort_request, 32'h1);
    chk("send", send_request, 32'h1);
    i_engine_model.pulse(2, ac);
    chk("abort", abort_request, 32'h0);
    chk("send", send_request, 32'h0);
    wr(IDX_TXQ_CTRL, QC | 32'h200);
    wr(IDX_TXQ_CTRL, QC | 32'h600);
    rchk("txq_ctrl", IDX_TXQ_CTRL, QC | 32'h80);
    chk("txq_ptrs", {txq_head, txq_tail, txq_empty}, 32'h1);
    // retry field set to none with the global limit on
    wr(IDX_TXQ_CTRL, 32'h0);
    chk("retry_eff", retry_limit_eff, 32'h0);
    // stamps off: a logged object is accepted but carries no stamp
    @(negedge clk);
    config_mode = 1'b1;
    wr(IDX_EVT_CTRL, 32'h0300_0000);
    @(negedge clk);
    config_mode = 1'b0;
    repeat (3) @(negedge clk);
    i_engine_model.pulse(0, ac);
    chk("accept_nostamp", ac, 32'h2);
    rchk("evt_addr", IDX_EVT_ADDR, BASE);
    end_sim();
  end

  initial begin
    #(20000 * 8);
    n_mismatch++;
    $display("watchdog expired");
    end_sim();
  end
endmodule : event_queue_ctrl_tb_top
